// ### include/ecf_defs.svh
// constants for the user counter and file load resource handler
`ifndef ECF_DEFS_SVH
`define ECF_DEFS_SVH

// ----------------------------------------------------------------
// resource identifiers and address byte fields
// ----------------------------------------------------------------
`define ECF_RSC_INC    10'h121
`define ECF_RSC_CLR    10'h122
`define ECF_RSC_OPEN   10'h130
`define ECF_AH_READ    6
`define ECF_AH_IND     5
`define ECF_AH_LONG    4
`define ECF_AH_LEN_HI  3
`define ECF_AH_LEN_LO  2
`define ECF_CTRL_GO    8'h01
`define ECF_LEN_ZERO   2'h0
`define ECF_LEN_EIGHT  2'h3

// ----------------------------------------------------------------
// descriptors, offsets, levels
// ----------------------------------------------------------------
`define ECF_OFF_VERIFY 16'h0000
`define ECF_OFF_SKIP   16'h0010
`define ECF_LVL_NONE   4'hf
`define ECF_WR_LVL_INC 8'h00
`define ECF_WR_LVL_CLR 8'h02
`define ECF_WR_LVL_OPN 8'h00
`define ECF_RD_LVL     8'h0f
`define ECF_SIZE_OPEN  8'h08
`define ECF_TYPE_EMPTY 8'h01
`define ECF_TYPE_STR   8'h0b
`define ECF_TIME_OVR   8'h00
`define ECF_CNT_MAX    32'hffff_ffff

// ----------------------------------------------------------------
// error codes and file store
// ----------------------------------------------------------------
`define ECF_ERR_OVF    16'h0023
`define ECF_ERR_CRC    16'h4315
`define ECF_ERR_ACCESS 16'h4101
`define ECF_ERR_NOFILE 16'h4102
`define ECF_ERR_PARAM  16'h4103
`define ECF_NFILES     4
`define ECF_CRC_POLY   8'h07

`endif

// ### include/ecf_pkg.sv
// types shared by both ends of the parameters channel
package ecf_pkg;

  typedef enum logic [0:0] {DS_IDLE, DS_EXEC} ecf_dst_t;
  typedef enum logic [0:0] {MS_IDLE, MS_WAIT} ecf_mst_t;

  // one stored user file
  typedef struct packed {
    logic        valid;
    logic [63:0] name;
    logic [7:0]  rights;   // [7:4] write level, [3:0] read level
    logic [31:0] data;
    logic [7:0]  crc;
  } ecf_file_t;

  typedef struct packed {
    ecf_dst_t        state;
    logic            rd;
    logic            ind;
    logic [1:0]      len;
    logic [9:0]      rsc;
    logic [15:0]     off;
    logic [63:0]     data;
    logic            free;
    logic            err;
    logic [15:0]     ecode;
    logic [63:0]     rdata;
    logic [31:0]     cnt;
    logic            loaded;
    logic [1:0]      lidx;
    ecf_file_t [3:0] files;
  } ecf_dev_st_t;

  typedef struct packed {
    ecf_mst_t    state;
    logic [7:0]  ah;
    logic [7:0]  al;
    logic [7:0]  oh;
    logic [7:0]  ol;
    logic [63:0] data;
    logic [7:0]  ctrl;
    logic        go;
    logic        ready;
    logic        done;
    logic        err;
    logic [15:0] ecode;
    logic [63:0] rdata;
  } ecf_mst_st_t;

endpackage

// ### include/ecf_if.sv
// parameters channel between the drive-side master and the encoder end
`timescale 1ns/1ps
interface ecf_if;
  logic [63:0] msg_data;               // byte n at [8n+7:8n]
  logic [7:0]  msg_resource_addr_high;
  logic [7:0]  msg_resource_addr_low;
  logic [7:0]  msg_offset_high;
  logic [7:0]  msg_offset_low;
  logic [7:0]  msg_control_byte;
  logic        msg_ctrl_wr;            // one-cycle write of the control byte
  logic        channel_free_flag;
  logic        msg_err;
  logic [15:0] msg_err_code;
  logic [63:0] msg_rd_data;

  modport master (
    output msg_data, msg_resource_addr_high, msg_resource_addr_low,
    output msg_offset_high, msg_offset_low, msg_control_byte, msg_ctrl_wr,
    input  channel_free_flag, msg_err, msg_err_code, msg_rd_data
  );
  modport device (
    input  msg_data, msg_resource_addr_high, msg_resource_addr_low,
    input  msg_offset_high, msg_offset_low, msg_control_byte, msg_ctrl_wr,
    output channel_free_flag, msg_err, msg_err_code, msg_rd_data
  );
endinterface

// ### hw/ecf_master.sv
// drive-side master issuing long messages on the parameters channel
`timescale 1ns/1ps
`include "ecf_defs.svh"
module ecf_master
  import ecf_pkg::*;
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  // channel towards the encoder
  ecf_if.master            lnk,
  // command from the user
  input  wire logic        i_cmd_valid,
  input  wire logic        i_cmd_read,
  input  wire logic        i_cmd_ind,
  input  wire logic [1:0]  i_cmd_len,
  input  wire logic [9:0]  i_cmd_rsc,
  input  wire logic [15:0] i_cmd_off,
  input  wire logic [63:0] i_cmd_data,
  // answer to the user
  output logic             o_cmd_ready,
  output logic             o_done,
  output logic             o_err,
  output logic [15:0]      o_err_code,
  output logic [63:0]      o_rdata
);

  ecf_mst_st_t s;
  ecf_mst_st_t n;

  // ----------------------------------------------------------------
  // address byte encoding
  // ----------------------------------------------------------------
  function automatic logic [7:0] addr_high(input logic rd, input logic ind,
                                           input logic [1:0] len, input logic [9:0] rsc);
    logic [7:0] a;
    a = 8'h00;
    a[`ECF_AH_READ] = rd;
    a[`ECF_AH_IND] = ind;
    a[`ECF_AH_LONG] = 1'b1;
    a[`ECF_AH_LEN_HI:`ECF_AH_LEN_LO] = len;
    a[1:0] = rsc[9:8];
    return a;
  endfunction

  // ----------------------------------------------------------------
  // issue and wait
  // ----------------------------------------------------------------
  // one command in flight; the user waits on o_cmd_ready
  always_comb begin
    n = s;
    n.go = 1'b0;
    n.done = 1'b0;
    case (s.state)
      MS_IDLE: begin
        if (i_cmd_valid) begin
          n.ah = addr_high(i_cmd_read, i_cmd_ind, i_cmd_len, i_cmd_rsc);
          n.al = i_cmd_rsc[7:0];
          n.oh = i_cmd_off[15:8];    // zero asks for verification
          n.ol = i_cmd_off[7:0];
          n.data = i_cmd_data;       // name byte 0 in the low byte
          n.ctrl = `ECF_CTRL_GO;
          n.go = 1'b1;
          n.ready = 1'b0;
          n.state = MS_WAIT;
        end
      end
      MS_WAIT: begin
        // the flag still reads high in the cycle of the control write, since
        // the encoder only takes the message on that edge; skip that sample
        if (!s.go && lnk.channel_free_flag) begin
          n.done = 1'b1;
          n.ready = 1'b1;
          n.err = lnk.msg_err;
          n.ecode = lnk.msg_err_code;
          n.rdata = lnk.msg_rd_data;
          n.state = MS_IDLE;
        end
      end
      default: n.state = MS_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s <= '0;
      s.state <= MS_IDLE;
      s.ready <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign lnk.msg_data = s.data;
  assign lnk.msg_resource_addr_high = s.ah;
  assign lnk.msg_resource_addr_low = s.al;
  assign lnk.msg_offset_high = s.oh;
  assign lnk.msg_offset_low = s.ol;
  assign lnk.msg_control_byte = s.ctrl;
  assign lnk.msg_ctrl_wr = s.go;
  assign o_cmd_ready = s.ready;
  assign o_done = s.done;
  assign o_err = s.err;
  assign o_err_code = s.ecode;
  assign o_rdata = s.rdata;

endmodule

// ### hw/ecf_device.sv
// encoder end: user counter increment/clear and file open resources
//
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "ecf_defs.svh"
module ecf_device
  import ecf_pkg::*;
(
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  // channel towards the master
  ecf_if.device            lnk,
  // access level currently set
  input  wire logic [3:0]  i_access_lvl,
  // file store maintenance
  input  wire logic        i_file_we,
  input  wire logic [1:0]  i_file_idx,
  input  wire logic [63:0] i_file_name,
  input  wire logic [7:0]  i_file_rights,
  input  wire logic [31:0] i_file_data,
  input  wire logic        i_file_flip,
  // status
  output logic [31:0]      o_counter,
  output logic             o_file_loaded,
  output logic [1:0]       o_file_idx
);

  ecf_dev_st_t s;
  ecf_dev_st_t n;
  logic        hit;
  logic [1:0]  hidx;
  logic [63:0] want;
  logic [3:0]  frd;
  logic [3:0]  fwr;
  logic        perm;
  logic        known;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // crc over the stored data word; recomputed on every store
  function automatic logic [7:0] crc8(input logic [31:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 31; i >= 0; i--) begin
      if (c[7] ^ d[i]) begin
        c = {c[6:0], 1'b0} ^ `ECF_CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction

  // fold case and blank everything after the terminator
  function automatic logic [63:0] norm_name(input logic [63:0] nm);
    logic [63:0] o;
    logic        ended;
    logic [7:0]  b;
    o = 64'h0;
    ended = 1'b0;
    for (int i = 0; i < 8; i++) begin
      b = nm[8*i +: 8];
      if (b == 8'h00) begin
        ended = 1'b1;
      end
      if (!ended) begin
        if (b >= 8'h61 && b <= 8'h7a) begin
          b = b - 8'h20;
        end
        o[8*i +: 8] = b;
      end
    end
    return o;
  endfunction

  // descriptor byte of a resource at a given offset
  function automatic logic [7:0] desc_byte(input logic [9:0] rsc, input logic [2:0] off);
    logic [7:0] v;
    v = 8'h00;
    case (off)
      3'd1: v = (rsc == `ECF_RSC_OPEN) ? `ECF_SIZE_OPEN : 8'h00;
      3'd2: v = `ECF_RD_LVL;
      3'd3: begin
        if (rsc == `ECF_RSC_CLR) begin
          v = `ECF_WR_LVL_CLR;
        end else if (rsc == `ECF_RSC_INC) begin
          v = `ECF_WR_LVL_INC;
        end else begin
          v = `ECF_WR_LVL_OPN;
        end
      end
      3'd4: v = `ECF_TIME_OVR;
      3'd5: v = (rsc == `ECF_RSC_OPEN) ? `ECF_TYPE_STR : `ECF_TYPE_EMPTY;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------
  // file lookup, by normalised name
  // ----------------------------------------------------------------
  always_comb begin
    hit = 1'b0;
    hidx = 2'd0;
    want = norm_name(s.data);
    for (int i = `ECF_NFILES - 1; i >= 0; i--) begin
      if (s.files[i].valid && norm_name(s.files[i].name) == want) begin
        hit = 1'b1;
        hidx = 2'(i);
      end
    end
    frd = s.files[hidx].rights[3:0];
    fwr = s.files[hidx].rights[7:4];
    perm = (frd != `ECF_LVL_NONE && i_access_lvl >= frd) ||
           (fwr != `ECF_LVL_NONE && i_access_lvl >= fwr);
    known = (s.rsc == `ECF_RSC_INC) || (s.rsc == `ECF_RSC_CLR) || (s.rsc == `ECF_RSC_OPEN);
  end

  // ----------------------------------------------------------------
  // command execution
  // ----------------------------------------------------------------
  // every message takes one execute cycle; new writes of the control
  // byte while busy are ignored, the master must wait for the flag
  always_comb begin
    n = s;
    case (s.state)
      DS_IDLE: begin
        if (lnk.msg_ctrl_wr && lnk.msg_control_byte == `ECF_CTRL_GO) begin
          n.rd = lnk.msg_resource_addr_high[`ECF_AH_READ];
          n.ind = lnk.msg_resource_addr_high[`ECF_AH_IND];
          n.len = lnk.msg_resource_addr_high[`ECF_AH_LEN_HI:`ECF_AH_LEN_LO];
          n.rsc = {lnk.msg_resource_addr_high[1:0], lnk.msg_resource_addr_low};
          n.off = {lnk.msg_offset_high, lnk.msg_offset_low};
          n.data = lnk.msg_data;
          n.free = 1'b0;
          n.state = DS_EXEC;
        end
      end
      DS_EXEC: begin
        n.state = DS_IDLE;
        n.free = 1'b1;
        n.err = 1'b0;
        n.ecode = 16'h0000;
        n.rdata = 64'h0;
        if (s.rd) begin
          // only the plain descriptor read is legal on these resources
          if (s.ind || !known || s.off[15:3] != 13'h0 || s.off[2:0] == 3'd0 || s.off[2:0] > 3'd5) begin
            n.err = 1'b1;
            n.ecode = `ECF_ERR_ACCESS;
          end else begin
            n.rdata = {56'h0, desc_byte(s.rsc, s.off[2:0])};
          end
        end else begin
          case (s.rsc)
            `ECF_RSC_INC: begin
              if (s.len != `ECF_LEN_ZERO || s.off != 16'h0000) begin
                n.err = 1'b1;
                n.ecode = `ECF_ERR_PARAM;
              end else if (s.cnt == `ECF_CNT_MAX) begin
                n.err = 1'b1;                    // counter held
                n.ecode = `ECF_ERR_OVF;
              end else begin
                n.cnt = s.cnt + 32'h0000_0001;
              end
            end
            `ECF_RSC_CLR: begin
              if (s.len != `ECF_LEN_ZERO || s.off != 16'h0000) begin
                n.err = 1'b1;
                n.ecode = `ECF_ERR_PARAM;
              end else if ({4'h0, i_access_lvl} < `ECF_WR_LVL_CLR) begin
                n.err = 1'b1;
                n.ecode = `ECF_ERR_ACCESS;
              end else begin
                n.cnt = 32'h0000_0000;
              end
            end
            `ECF_RSC_OPEN: begin
              n.loaded = 1'b0;                   // old file discarded
              if (s.len != `ECF_LEN_EIGHT) begin
                n.err = 1'b1;
                n.ecode = `ECF_ERR_PARAM;
              end else if (s.off != `ECF_OFF_VERIFY && s.off != `ECF_OFF_SKIP) begin
                n.err = 1'b1;                    // reserved offset
                n.ecode = `ECF_ERR_PARAM;
              end else if (!hit) begin
                n.err = 1'b1;
                n.ecode = `ECF_ERR_NOFILE;
              end else if (!perm) begin
                n.err = 1'b1;
                n.ecode = `ECF_ERR_ACCESS;
              end else if (s.off == `ECF_OFF_VERIFY &&
                           crc8(s.files[hidx].data) != s.files[hidx].crc) begin
                n.err = 1'b1;
                n.ecode = `ECF_ERR_CRC;
              end else begin
                n.loaded = 1'b1;                 // held until next open or reset
                n.lidx = hidx;
              end
            end
            default: begin
              n.err = 1'b1;
              n.ecode = `ECF_ERR_ACCESS;
            end
          endcase
        end
      end
      default: n.state = DS_IDLE;
    endcase

    // maintenance store; a store wins over a corruption of the same cycle
    if (i_file_we) begin
      n.files[i_file_idx].valid = 1'b1;
      n.files[i_file_idx].name = i_file_name;
      n.files[i_file_idx].rights = i_file_rights;
      n.files[i_file_idx].data = i_file_data;
      n.files[i_file_idx].crc = crc8(i_file_data);
    end else if (i_file_flip) begin
      n.files[i_file_idx].data[0] = ~s.files[i_file_idx].data[0];
    end
  end

  // state register; reset also unloads the file
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s <= '0;
      s.state <= DS_IDLE;
      s.free <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign lnk.channel_free_flag = s.free;
  assign lnk.msg_err = s.err;
  assign lnk.msg_err_code = s.ecode;
  assign lnk.msg_rd_data = s.rdata;
  assign o_counter = s.cnt;
  assign o_file_loaded = s.loaded;
  assign o_file_idx = s.lidx;

endmodule

// ### verif/ecf_assertions.sv
// concurrent checks on the parameters channel between master and encoder end
`timescale 1ns/1ps
module ecf_assertions (
  // clock and reset
  input wire logic        i_clk,
  input wire logic        i_rst_b,
  // master side of the channel
  input wire logic [7:0]  msg_resource_addr_high,
  input wire logic [7:0]  msg_resource_addr_low,
  input wire logic [7:0]  msg_offset_high,
  input wire logic [7:0]  msg_offset_low,
  input wire logic [7:0]  msg_control_byte,
  input wire logic        msg_ctrl_wr,
  // device side of the channel
  input wire logic        channel_free_flag,
  input wire logic        msg_err,
  input wire logic [15:0] msg_err_code,
  input wire logic [63:0] msg_rd_data
);
  logic        take;
  logic        rd_dir;
  logic [9:0]  rsc;
  logic [15:0] off;

  // ----------------------------------------------------------------
  // message decode
  // ----------------------------------------------------------------
  // only an idle device that sees the go code takes a message
  assign take   = msg_ctrl_wr && (msg_control_byte == 8'h01) && channel_free_flag;
  assign rd_dir = take && msg_resource_addr_high[6] && !msg_resource_addr_high[5];
  assign rsc    = {msg_resource_addr_high[1:0], msg_resource_addr_low};
  assign off    = {msg_offset_high, msg_offset_low};

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  // ----------------------------------------------------------------
  // handshake and answers
  // ----------------------------------------------------------------
  AST_TAKE_BUSY: assert property (take |=> !channel_free_flag ##1 channel_free_flag)
    else $error("free flag did not drop for exactly one cycle");
  AST_BUSY_ONE: assert property (!channel_free_flag |=> channel_free_flag)
    else $error("free flag stayed low");
  AST_CTRL_GO: assert property (msg_ctrl_wr |-> msg_control_byte == 8'h01)
    else $error("control byte not the go code");
  // status must stand untouched while the channel sits idle
  AST_ERR_HOLDS: assert property (channel_free_flag && !take |=> $stable(msg_err) && $stable(msg_err_code))
    else $error("error status changed while idle");
  AST_INC_RDLVL: assert property (rd_dir && rsc == 10'h121 && off == 16'h0002 |-> ##2 !msg_err && msg_rd_data[7:0] == 8'h0f)
    else $error("increment read level wrong");
  AST_INC_TYPE: assert property (rd_dir && rsc == 10'h121 && off == 16'h0005 |-> ##2 !msg_err && msg_rd_data[7:0] == 8'h01)
    else $error("increment data type wrong");
  AST_CLR_WRLVL: assert property (rd_dir && rsc == 10'h122 && off == 16'h0003 |-> ##2 !msg_err && msg_rd_data[7:0] == 8'h02)
    else $error("clear write level wrong");
  AST_OPEN_SIZE: assert property (rd_dir && rsc == 10'h130 && off == 16'h0001 |-> ##2 !msg_err && msg_rd_data[7:0] == 8'h08)
    else $error("file open data size wrong");
  AST_IND_REFUSED: assert property (take && msg_resource_addr_high[6] && msg_resource_addr_high[5]
                                    |-> ##2 msg_err && msg_err_code == 16'h4101)
    else $error("indirect read not refused");
  AST_OPEN_RESV: assert property (take && !msg_resource_addr_high[6] && rsc == 10'h130 && off != 16'h0000
                                  && off != 16'h0010 |-> ##2 msg_err && msg_err_code == 16'h4103)
    else $error("reserved open offset not refused");
endmodule

// ### verif/ecf_tb.sv
// self-checking bench joining master and encoder end over the parameters channel
`timescale 1ns/1ps
`include "ecf_defs.svh"
module ecf_tb;
  logic        i_clk;
  logic        i_rst_b;
  logic        cmd_valid;
  logic        cmd_read;
  logic        cmd_ind;
  logic [1:0]  cmd_len;
  logic [9:0]  cmd_rsc;
  logic [15:0] cmd_off;
  logic [63:0] cmd_data;
  logic        cmd_ready;
  logic        done;
  logic        err;
  logic [15:0] err_code;
  logic [63:0] rdata;
  logic [3:0]  lvl;
  logic        f_we;
  logic        f_flip;
  logic [1:0]  f_idx;
  logic [63:0] f_name;
  logic [7:0]  f_rights;
  logic [31:0] f_data;
  logic [31:0] counter;
  logic        loaded;
  logic [1:0]  lidx;
  int          n_errors;
  int          checks;
  // descriptor bytes at offsets 1..5 for increment, clear, file open
  localparam logic [7:0] DESC [0:14] = '{8'h00, 8'h0f, 8'h00, 8'h00, 8'h01, 8'h00, 8'h0f, 8'h02,
                                         8'h00, 8'h01, 8'h08, 8'h0f, 8'h00, 8'h00, 8'h0b};
  localparam logic [9:0] RSCS [0:2] = '{10'h121, 10'h122, 10'h130};
  // names, first byte lowest; JUNK1 is FILE1 with junk after its terminator
  localparam logic [63:0] N_FILE1 = 64'h0000_0031_454c_4946;
  localparam logic [63:0] N_JUNK1 = 64'h7978_0031_454c_4946;
  localparam logic [63:0] N_LOWER = 64'h0000_0000_0063_6261;
  localparam logic [63:0] N_UPPER = 64'h0000_0000_0043_4241;
  localparam logic [63:0] N_BAD   = 64'h0000_0000_0044_4142;

  // ----------------------------------------------------------------
  // clock, design and checker
  // ----------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  ecf_if ecf_if_i ();
  ecf_master ecf_master_i (.i_clk(i_clk), .i_rst_b(i_rst_b), .lnk(ecf_if_i.master), .i_cmd_valid(cmd_valid),
    .i_cmd_read(cmd_read), .i_cmd_ind(cmd_ind), .i_cmd_len(cmd_len), .i_cmd_rsc(cmd_rsc), .i_cmd_off(cmd_off),
    .i_cmd_data(cmd_data), .o_cmd_ready(cmd_ready), .o_done(done), .o_err(err), .o_err_code(err_code),
    .o_rdata(rdata));
  ecf_device ecf_device_i (.i_clk(i_clk), .i_rst_b(i_rst_b), .lnk(ecf_if_i.device), .i_access_lvl(lvl),
    .i_file_we(f_we), .i_file_idx(f_idx), .i_file_name(f_name), .i_file_rights(f_rights), .i_file_data(f_data),
    .i_file_flip(f_flip), .o_counter(counter), .o_file_loaded(loaded), .o_file_idx(lidx));
  ecf_assertions ecf_assertions_i (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .msg_resource_addr_high(ecf_if_i.msg_resource_addr_high), .msg_resource_addr_low(ecf_if_i.msg_resource_addr_low),
    .msg_offset_high(ecf_if_i.msg_offset_high), .msg_offset_low(ecf_if_i.msg_offset_low),
    .msg_control_byte(ecf_if_i.msg_control_byte), .msg_ctrl_wr(ecf_if_i.msg_ctrl_wr),
    .channel_free_flag(ecf_if_i.channel_free_flag), .msg_err(ecf_if_i.msg_err),
    .msg_err_code(ecf_if_i.msg_err_code), .msg_rd_data(ecf_if_i.msg_rd_data));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one long message through the user port; waits for done under a bound
  task automatic msg(input logic rd, input logic ind, input logic [1:0] len, input logic [9:0] rsc,
                     input logic [15:0] off, input logic [63:0] data);
    int n;
    @(posedge i_clk);
    cmd_valid <= 1'b1;
    cmd_read  <= rd;
    cmd_ind   <= ind;
    cmd_len   <= len;
    cmd_rsc   <= rsc;
    cmd_off   <= off;
    cmd_data  <= data;
    @(posedge i_clk);
    cmd_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge i_clk);
      #1;
      n++;
      if (n == 1)
        chk(64'(cmd_ready), 64'd0);
    end while (done !== 1'b1 && n < 8);
    chk(64'(n), 64'd3);
    chk(64'(cmd_ready), 64'd1);
  endtask

  task automatic expect_err(input logic e, input logic [15:0] code);
    chk(64'(err), 64'(e));
    if (e)
      chk(64'(err_code), 64'(code));
  endtask

  task automatic set_lvl(input logic [3:0] l);
    @(posedge i_clk);
    lvl <= l;
  endtask

  // store or corrupt one file entry; corruption leaves the checksum stale
  task automatic store(input logic [1:0] idx, input logic [63:0] name, input logic [7:0] rights, input logic fl);
    @(posedge i_clk);
    f_idx    <= idx;
    f_name   <= name;
    f_rights <= rights;
    f_data   <= 32'h1234_5678;
    f_we     <= !fl;
    f_flip   <= fl;
    @(posedge i_clk);
    f_we     <= 1'b0;
    f_flip   <= 1'b0;
  endtask

  task automatic open(input logic [63:0] name, input logic [15:0] off, input logic e, input logic [15:0] code,
                      input logic l, input logic [1:0] idx);
    msg(1'b0, 1'b0, 2'h3, 10'h130, off, name);
    expect_err(e, code);
    chk(64'(loaded), 64'(l));
    if (l)
      chk(64'(lidx), 64'(idx));
  endtask

  task automatic do_reset;
    @(posedge i_clk);
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1'b1;
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_counter;
    for (int k = 1; k <= 3; k++) begin
      msg(1'b0, 1'b0, 2'h0, 10'h121, 16'h0000, 64'h0);
      expect_err(1'b0, 16'h0000);
      chk(64'(counter), 64'(k));
    end
    msg(1'b0, 1'b0, 2'h1, 10'h121, 16'h0000, 64'h0);
    expect_err(1'b1, `ECF_ERR_PARAM);
    set_lvl(4'h1);
    msg(1'b0, 1'b0, 2'h0, 10'h122, 16'h0000, 64'h0);
    expect_err(1'b1, `ECF_ERR_ACCESS);
    chk(64'(counter), 64'd3);
    set_lvl(4'h2);
    msg(1'b0, 1'b0, 2'h0, 10'h122, 16'h0000, 64'h0);
    expect_err(1'b0, 16'h0000);
    chk(64'(counter), 64'h0000_0000);
    $display("counter test done");
  endtask

  // every descriptor byte of all three resources, then refused reads
  task automatic test_desc;
    for (int i = 0; i < 3; i++) begin
      for (int o = 1; o <= 5; o++) begin
        msg(1'b1, 1'b0, 2'h0, RSCS[i], 16'(o), 64'h0);
        expect_err(1'b0, 16'h0000);
        chk(64'(rdata[7:0]), 64'(DESC[i * 5 + o - 1]));
      end
    end
    msg(1'b1, 1'b1, 2'h0, 10'h121, 16'h0001, 64'h0);
    expect_err(1'b1, `ECF_ERR_ACCESS);
    msg(1'b1, 1'b0, 2'h0, 10'h122, 16'h0000, 64'h0);
    expect_err(1'b1, `ECF_ERR_ACCESS);
    $display("descriptor test done");
  endtask

  task automatic test_files;
    set_lvl(4'h0);
    store(2'd0, N_FILE1, 8'h00, 1'b0);
    store(2'd1, N_LOWER, 8'h33, 1'b0);
    store(2'd2, N_BAD, 8'h00, 1'b0);
    store(2'd2, N_BAD, 8'h00, 1'b1);
    open(N_JUNK1, 16'h0000, 1'b0, 16'h0000, 1'b1, 2'd0);
    open(N_LOWER, 16'h0010, 1'b1, `ECF_ERR_ACCESS, 1'b0, 2'd0);
    set_lvl(4'h3);
    open(N_UPPER, 16'h0000, 1'b0, 16'h0000, 1'b1, 2'd1);
    open(N_BAD, 16'h0000, 1'b1, 16'h4315, 1'b0, 2'd0);
    open(N_BAD, 16'h0010, 1'b0, 16'h0000, 1'b1, 2'd2);
    open(N_FILE1, 16'h0001, 1'b1, `ECF_ERR_PARAM, 1'b0, 2'd0);
    open(N_FILE1, 16'h0000, 1'b0, 16'h0000, 1'b1, 2'd0);
    do_reset();
    @(posedge i_clk);
    #1;
    chk(64'(loaded), 64'd0);
    chk(64'(ecf_if_i.channel_free_flag), 64'd1);
    $display("file test done");
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    i_rst_b   = 1'b0;
    cmd_valid = 1'b0;
    cmd_read  = 1'b0;
    cmd_ind   = 1'b0;
    cmd_len   = 2'h0;
    cmd_rsc   = 10'h000;
    cmd_off   = 16'h0000;
    cmd_data  = 64'h0;
    lvl       = 4'h0;
    f_we      = 1'b0;
    f_flip    = 1'b0;
    f_idx     = 2'd0;
    f_name    = 64'h0;
    f_rights  = 8'h00;
    f_data    = 32'h0000_0000;
    n_errors  = 0;
    checks    = 0;
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1'b1;
    test_counter();
    test_desc();
    test_files();
    wrap_up();
  end

  // the run needs under two hundred cycles; ten thousand means a hang
  initial begin
    #(10000 * 100);
    n_errors++;
    wrap_up();
  end
endmodule
